// ---- rtl/pirq_top.sv ----
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// - fixed base address per peripheral region
// - checksum unit at 0x0120, failure on vector 1
// - condition sets its sticky flag bit
// - enable bit written by software, held
// - request only when enable and flag set; source 0 (vector 1) requests on its flag alone
// - request stays until flag cleared
// - global enable off masks all maskable requests
// - one vector per instance, vector 0 reset
// - voltage monitor 2, pin ports 3 to 5
// - counter 6, periodic tick timer 7
// - timer A on vectors 8 to 12
// - serial interfaces on vectors 24 to 29
// - revision identifier readable by processor
// - revision at offset 0x01, read only
module pirq_top #(
   parameter logic [7:0] REV_ID = 8'h00 // Arbitrary value
) (
   input  wire logic                               core_clk,
   input  wire logic                               rst_n,
   input  wire logic [pirq_pkg::ADDR_W-1:0]        busAddr,
   input  wire logic [pirq_pkg::DATA_W-1:0]        busWrData,
   input  wire logic                               busWrEn,
   input  wire logic                               busRdEn,
   output logic      [pirq_pkg::DATA_W-1:0]        busRdData,
   input  wire logic [pirq_pkg::NSRC-1:0]          srcEvent,
   input  wire logic                               coreIntEn,
   output logic                                    irqOut,
   output logic                                    vecValid,
   output logic      [pirq_pkg::VEC_W-1:0]         vecNum,
   output logic                                    regionHit,
   output logic      [pirq_pkg::RGN_W-1:0]         regionSel
);

   // ==========================================================
   // Helper functions
   function automatic logic [pirq_pkg::RGN_W:0] decodeRegion(
      input logic [pirq_pkg::ADDR_W-1:0] a);
      logic [pirq_pkg::RGN_W:0] r;
      r = '0;
      for (int i = 0; i < pirq_pkg::NREGION; i++) begin
         if (a >= pirq_pkg::REGION_BASE[i] && a < pirq_pkg::MAP_END) begin
            r = {1'b1, pirq_pkg::RGN_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic int laneOf(input logic [pirq_pkg::ADDR_W-1:0] a,
                                 input logic [pirq_pkg::ADDR_W-1:0] base);
      int l;
      l = -1;
      if (a >= base && a < base + pirq_pkg::ADDR_W'(pirq_pkg::IRQ_BYTES)) begin
         l = int'(a - base);
      end
      return l;
   endfunction

   function automatic logic [pirq_pkg::FLAG_W-1:0] laneMask(input int l,
                                                         input logic [7:0] d);
      logic [pirq_pkg::FLAG_W-1:0] m;
      m = '0;
      if (l >= 0) begin
         m[l*8 +: 8] = d;
      end
      return m;
   endfunction

   // ==========================================================
   // State
   logic [pirq_pkg::FLAG_W-1:0] flag_q, flag_d;
   logic [pirq_pkg::FLAG_W-1:0] enable_q, enable_d;
   logic [pirq_pkg::DATA_W-1:0] rdData_q, rdData_d;
   logic                        irq_q, irq_d;
   logic                        vecValid_q, vecValid_d;
   logic [pirq_pkg::VEC_W-1:0]  vecNum_q, vecNum_d;
   logic                        rgnHit_q, rgnHit_d;
   logic [pirq_pkg::RGN_W-1:0]  rgnSel_q, rgnSel_d;

   logic [pirq_pkg::NSRC-1:0]   pending;
   logic                        anyPending;
   logic [pirq_pkg::VEC_W-1:0]  pickVec;
   logic [pirq_pkg::FLAG_W-1:0] setMask, clrMask;
   logic [pirq_pkg::FLAG_W-1:0] srcWide;
   logic [pirq_pkg::RGN_W:0]    rgn;
   int                          clrLane, enLane, stLane;

   // ==========================================================
   // Request formation
   always_comb begin
      pending = flag_q[pirq_pkg::NSRC-1:0] & enable_q[pirq_pkg::NSRC-1:0];
      if (!coreIntEn) begin
         pending = '0;
      end
      pending[pirq_pkg::NMI_SRC] = flag_q[pirq_pkg::NMI_SRC];
   end

   pirq_vec_pick u_pick (
      .pending    (pending),
      .anyPending (anyPending),
      .vector     (pickVec)
   );

   // ==========================================================
   // Flags, enables and bus
   always_comb begin
      srcWide  = '0;
      srcWide[pirq_pkg::NSRC-1:0] = srcEvent;
      clrLane  = laneOf(busAddr, pirq_pkg::ADR_IRQ_CLEAR);
      enLane   = laneOf(busAddr, pirq_pkg::ADR_IRQ_STATUS == busAddr ? 16'h0000 :
                        pirq_pkg::ADR_IRQ_ENABLE);
      stLane   = laneOf(busAddr, pirq_pkg::ADR_IRQ_STATUS);
      setMask  = srcWide;
      clrMask  = busWrEn ? laneMask(clrLane, busWrData) : '0;
      flag_d   = (flag_q & ~clrMask) | setMask;
      flag_d[pirq_pkg::FLAG_W-1:pirq_pkg::NSRC] = '0;
      enable_d = enable_q;
      if (busWrEn && enLane >= 0) begin
         enable_d[enLane*8 +: 8] = busWrData;
      end
      enable_d[pirq_pkg::FLAG_W-1:pirq_pkg::NSRC] = '0;

      rdData_d = pirq_pkg::RDATA_RST;
      if (busRdEn) begin
         if (busAddr == pirq_pkg::ADR_REV_ID) begin
            rdData_d = REV_ID;
         end else if (stLane >= 0) begin
            rdData_d = flag_q[stLane*8 +: 8];
         end else if (enLane >= 0) begin
            rdData_d = enable_q[enLane*8 +: 8];
         end else if (busAddr == pirq_pkg::ADR_IRQ_VECTOR) begin
            rdData_d = {vecValid_q, 2'b00, vecNum_q};
         end
      end

      rgn      = decodeRegion(busAddr);
      rgnHit_d = rgnHit_q;
      rgnSel_d = rgnSel_q;
      if (busRdEn || busWrEn) begin
         rgnHit_d = rgn[pirq_pkg::RGN_W];
         rgnSel_d = rgn[pirq_pkg::RGN_W-1:0];
      end

      irq_d      = anyPending;
      vecValid_d = anyPending;
      vecNum_d   = pickVec;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flag_q     <= pirq_pkg::FLAG_RST;
         enable_q   <= pirq_pkg::ENABLE_RST;
         rdData_q   <= pirq_pkg::RDATA_RST;
         irq_q      <= 1'b0;
         vecValid_q <= 1'b0;
         vecNum_q   <= pirq_pkg::VEC_RESET;
         rgnHit_q   <= 1'b0;
         rgnSel_q   <= '0;
      end else begin
         flag_q     <= flag_d;
         enable_q   <= enable_d;
         rdData_q   <= rdData_d;
         irq_q      <= irq_d;
         vecValid_q <= vecValid_d;
         vecNum_q   <= vecNum_d;
         rgnHit_q   <= rgnHit_d;
         rgnSel_q   <= rgnSel_d;
      end
   end

   assign busRdData = rdData_q;
   assign irqOut    = irq_q;
   assign vecValid  = vecValid_q;
   assign vecNum    = vecNum_q;
   assign regionHit = rgnHit_q;
   assign regionSel = rgnSel_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   nmi_vector_a: assert property (flag_q[pirq_pkg::NMI_SRC] |=>
      vecValid_q && vecNum_q == pirq_pkg::VEC_NMI)
      else $error("NMI flag did not present vector 1");

   flag_set_a: assert property (|srcEvent |=>
      (flag_q[pirq_pkg::NSRC-1:0] & $past(srcEvent)) == $past(srcEvent))
      else $error("Event did not set its flag");

   enable_hold_a: assert property (!(busWrEn && busAddr >= pirq_pkg::ADR_IRQ_ENABLE &&
      busAddr < pirq_pkg::ADR_IRQ_VECTOR) |=> $stable(enable_q))
      else $error("Enable changed without a write");

   request_form_a: assert property (coreIntEn && flag_q[5] && enable_q[5] &&
      $stable(flag_q) && $stable(enable_q) |=> vecValid_q ##0 irqOut)
      else $error("Enabled flag gave no request");

   flag_hold_a: assert property (!(busWrEn && busAddr == pirq_pkg::ADR_IRQ_CLEAR) &&
      !(busWrEn && busAddr == pirq_pkg::ADR_IRQ_CLEAR + 16'h0001) &&
      !(busWrEn && busAddr == pirq_pkg::ADR_IRQ_CLEAR + 16'h0002)
      |=> (flag_q & $past(flag_q)) == $past(flag_q))
      else $error("Flag dropped without a clear");

   global_mask_a: assert property (!coreIntEn && !flag_q[pirq_pkg::NMI_SRC] |=>
      !vecValid_q && !irqOut)
      else $error("Request seen with global enable off");

   vec_legal_a: assert property (vecValid_q |->
      vecNum_q != pirq_pkg::VEC_RESET && pirq_pkg::vecAssigned(vecNum_q))
      else $error("Unassigned vector presented");

   timer_a_vec_a: assert property (coreIntEn && flag_q[7] && enable_q[7] &&
      flag_q[6:0] == 7'h00 |=> vecNum_q == 5'h08)
      else $error("Timer A overflow not on vector 8");

   rev_read_a: assert property (busRdEn && busAddr == pirq_pkg::ADR_REV_ID |=>
      busRdData == REV_ID)
      else $error("Revision read wrong");

   region_config_a: assert property ((busRdEn || busWrEn) &&
      busAddr == pirq_pkg::ADR_REV_ID |=> regionHit && regionSel == pirq_pkg::RGN_SYS_CFG)
      else $error("System configuration region not decoded");

endmodule

// ---- inc/pirq_pkg.sv ----
package pirq_pkg;
   // ==========================================================
   // Widths
   localparam int ADDR_W  = 16;
   localparam int DATA_W  = 8;
   localparam int VEC_W   = 5;
   localparam int NSRC    = 23;
   localparam int NREGION = 32;
   localparam int RGN_W   = 5;
   localparam int FLAG_W  = 24;

   // ==========================================================
   // Peripheral base addresses, ascending
   localparam logic [ADDR_W-1:0] REGION_BASE [NREGION] = '{
      16'h0000, 16'h0004, 16'h0008, 16'h001C, 16'h0030, 16'h0040, 16'h0050, 16'h0060,
      16'h0080, 16'h00A0, 16'h0100, 16'h0110, 16'h0120, 16'h0140, 16'h0180, 16'h01C0,
      16'h0200, 16'h0400, 16'h0420, 16'h0440, 16'h0600, 16'h0680, 16'h0800, 16'h0810,
      16'h0820, 16'h0A00, 16'h0A40, 16'h0F00, 16'h1000, 16'h1100, 16'h1280, 16'h1300};
   localparam logic [ADDR_W-1:0] MAP_END     = 16'h1340;
   localparam logic [RGN_W-1:0]  RGN_RSTCTRL = 5'h05;
   localparam logic [RGN_W-1:0]  RGN_CPUINT  = 5'h0B;
   localparam logic [RGN_W-1:0]  RGN_SCAN_CHK = 5'h0C;
   localparam logic [RGN_W-1:0]  RGN_SYS_CFG  = 5'h1B;
   localparam logic [RGN_W-1:0]  RGN_NVMCTRL = 5'h1C;

   // ==========================================================
   // Register addresses
   localparam logic [ADDR_W-1:0] SYS_CFG_BASE   = 16'h0F00;
   localparam logic [ADDR_W-1:0] REV_ID_OFS     = 16'h0001;
   localparam logic [ADDR_W-1:0] ADR_REV_ID     = SYS_CFG_BASE + REV_ID_OFS;
   localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 16'h0110;
   localparam logic [ADDR_W-1:0] ADR_IRQ_CLEAR  = 16'h0113;
   localparam logic [ADDR_W-1:0] ADR_IRQ_ENABLE = 16'h0116;
   localparam logic [ADDR_W-1:0] ADR_IRQ_VECTOR = 16'h0119;
   localparam int                IRQ_BYTES      = 3;

   // ==========================================================
   // Reset values
   localparam logic [FLAG_W-1:0] FLAG_RST   = 24'h000000;
   localparam logic [FLAG_W-1:0] ENABLE_RST = 24'h000000;
   localparam logic [DATA_W-1:0] RDATA_RST  = 8'h00;

   // ==========================================================
   // Source index to vector number
   localparam int NMI_SRC = 0;
   localparam logic [VEC_W-1:0] SRC_VEC [NSRC] = '{
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h11, 5'h14, 5'h15,
      5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E};
   localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
   localparam logic [VEC_W-1:0] VEC_NMI   = 5'h01;

   function automatic logic vecAssigned(input logic [VEC_W-1:0] v);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (SRC_VEC[i] == v) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction
endpackage

// ---- rtl/pirq_vec_pick.sv ----
`timescale 1ns/1ps
// Lowest pending vector; table is ascending so lowest source wins
module pirq_vec_pick (
   input  wire logic [pirq_pkg::NSRC-1:0]  pending,
   output logic                            anyPending,
   output logic      [pirq_pkg::VEC_W-1:0] vector
);
   always_comb begin
      anyPending = 1'b0;
      vector     = pirq_pkg::VEC_RESET;
      for (int i = pirq_pkg::NSRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            anyPending = 1'b1;
            vector     = pirq_pkg::SRC_VEC[i];
         end
      end
   end
endmodule

// ---- sim/pirq_core_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Core side: holds global enable, takes vectors
module pirq_core_model (
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic                       gieReq,
   output logic                            coreIntEn,
   input  wire logic                       vecValid,
   input  wire logic [pirq_pkg::VEC_W-1:0] vecNum,
   output logic      [pirq_pkg::VEC_W-1:0] takenVec
);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         coreIntEn <= 1'b0;
         takenVec  <= 5'h00;
      end else begin
         coreIntEn <= gieReq;
         if (vecValid) begin
            takenVec <= vecNum;
         end
      end
   end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
   logic        core_clk;
   logic        rst_n;
   logic [15:0] busAddr;
   logic [7:0]  busWrData;
   logic        busWrEn;
   logic        busRdEn;
   logic [7:0]  busRdData;
   logic [22:0] srcEvent;
   logic        gieReq;
   logic        coreIntEn;
   logic        irqOut;
   logic        vecValid;
   logic [4:0]  vecNum;
   logic [4:0]  takenVec;
   logic        regionHit;
   logic [4:0]  regionSel;
   int          n_mismatch;
   int          num_checks;
   int          cycles;
   localparam logic [7:0]  REV = 8'h5A; // Arbitrary value
   localparam logic [4:0]  VEC [23] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h11, 5'h14, 5'h15, 5'h18, 5'h19, 5'h1A,
      5'h1B, 5'h1C, 5'h1D, 5'h1E};
   localparam logic [15:0] RADR [5] = '{16'h0040, 16'h0120, 16'h0F00, 16'h1300, 16'h133F};
   localparam logic [4:0]  RSEL [5] = '{5'h05, 5'h0C, 5'h1B, 5'h1F, 5'h1F};

   pirq_top #(.REV_ID(REV)) i_pirq_top (.core_clk(core_clk), .rst_n(rst_n),
      .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn),
      .busRdData(busRdData), .srcEvent(srcEvent), .coreIntEn(coreIntEn), .irqOut(irqOut),
      .vecValid(vecValid), .vecNum(vecNum), .regionHit(regionHit), .regionSel(regionSel));
   pirq_core_model i_pirq_core_model (.core_clk(core_clk), .rst_n(rst_n), .gieReq(gieReq),
      .coreIntEn(coreIntEn), .vecValid(vecValid), .vecNum(vecNum), .takenVec(takenVec));

   // ==========================================================
   // Clock, watchdog, verdict
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Bus and event tasks
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      busAddr   <= a;
      busWrData <= d;
      busWrEn   <= 1'b1;
      @(posedge core_clk);
      busWrEn   <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      busAddr <= a;
      busRdEn <= 1'b1;
      @(posedge core_clk);
      busRdEn <= 1'b0;
      #1 d = busRdData;
   endtask
   // Pulse events, land at output check point
   task automatic fire(input logic [22:0] m);
      @(posedge core_clk);
      srcEvent <= m;
      @(posedge core_clk);
      srcEvent <= 23'h000000;
      tick(1);
      #1;
   endtask
   task automatic clr(input int i);
      wr(16'h0113 + 16'(i / 8), 8'h01 << (i % 8));
      tick(2);
      #1;
   endtask

   // ==========================================================
   // Tests
   initial begin
      logic [7:0] d;
      rst_n     = 1'b0;
      busAddr   = 16'h0000;
      busWrData = 8'h00;
      busWrEn   = 1'b0;
      busRdEn   = 1'b0;
      srcEvent  = 23'h000000;
      gieReq    = 1'b0;
      tick(20);
      rst_n  <= 1'b1;
      gieReq <= 1'b1;
      rd(16'h0110, d);
      `CHK(d, 8'h00)
      `CHK(irqOut, 1'b0)
      rd(16'h0F01, d);
      `CHK(d, REV)
      `CHK(regionSel, 5'h1B)
      wr(16'h0F01, ~REV);
      rd(16'h0F01, d);
      `CHK(d, REV)
      for (int i = 0; i < 5; i++) begin
         rd(RADR[i], d);
         `CHK({regionHit, regionSel}, {1'b1, RSEL[i]})
      end
      rd(16'h1340, d);
      `CHK({regionHit, d}, 9'h000)
      for (int i = 0; i < 3; i++) begin
         wr(16'h0116 + 16'(i), 8'hFF);
         rd(16'h0116 + 16'(i), d);
         `CHK(d, (i == 2) ? 8'h7F : 8'hFF)
      end
      for (int i = 0; i < 23; i++) begin
         fire(23'h000001 << i);
         `CHK({irqOut, vecValid, vecNum}, {2'b11, VEC[i]})
         rd(16'h0119, d);
         `CHK(d, {3'b100, VEC[i]})
         `CHK(takenVec, VEC[i])
         tick(8);
         #1 `CHK(vecValid, 1'b1)
         clr(i);
         `CHK({irqOut, vecValid, vecNum}, 7'h00)
      end
      fire(23'h000408);
      `CHK(vecNum, 5'h04)
      clr(3);
      `CHK(vecNum, 5'h0B)
      clr(10);
      wr(16'h0116, 8'hDF);
      fire(23'h000020);
      `CHK(irqOut, 1'b0)
      rd(16'h0110, d);
      `CHK(d, 8'h20)
      wr(16'h0116, 8'hFF);
      tick(2);
      #1 `CHK({irqOut, vecNum}, 6'h26)
      clr(5);
      fire(23'h000080);
      @(posedge core_clk);
      gieReq <= 1'b0;
      tick(3);
      #1 `CHK(vecValid, 1'b0)
      fire(23'h000001);
      `CHK({irqOut, vecNum}, 6'h21)
      clr(0);
      @(posedge core_clk);
      gieReq <= 1'b1;
      tick(3);
      #1 `CHK(vecNum, 5'h08)
      clr(7);
      give_verdict();
   end
endmodule
